/* verilog/pmb_pkg.sv */
// pmb_pkg: register map, field positions, reset values and carrier types
// for the regulator control register bank.
// assumes: every file of the bank imports this package whole.
package pmb_pkg;

    // serial port device address (7-bit)
    localparam logic [6:0] DEV_ADDR = 7'h60;

    // register indices as sent after the device address
    localparam logic [7:0] OFF_DEVICE_REVISION   = 8'h00;
    localparam logic [7:0] OFF_FACTORY_REVISION  = 8'h01;
    localparam logic [7:0] OFF_BUCK_A_CONTROL    = 8'h02;
    localparam logic [7:0] OFF_PGOOD_CONFIG_ONE  = 8'h15;
    localparam logic [7:0] OFF_PGOOD_CONFIG_TWO  = 8'h16;
    localparam logic [7:0] OFF_PGOOD_FAULT       = 8'h17;
    localparam logic [7:0] OFF_SOFTWARE_RESET    = 8'h18;
    localparam logic [7:0] OFF_TOP_FLAGS_ONE     = 8'h19;
    localparam logic [7:0] OFF_TOP_FLAGS_TWO     = 8'h1A;
    localparam logic [7:0] OFF_SWITCHER_FLAGS    = 8'h1B;
    localparam logic [7:0] OFF_LINEAR_FLAGS      = 8'h1C;
    localparam logic [7:0] OFF_TOP_LIVE          = 8'h1D;
    localparam logic [7:0] OFF_SWITCHER_LIVE     = 8'h1E;
    localparam logic [7:0] OFF_LINEAR_LIVE       = 8'h1F;
    localparam logic [7:0] OFF_TOP_MASKS_ONE     = 8'h20;
    localparam logic [7:0] OFF_TOP_MASKS_TWO     = 8'h21;
    localparam logic [7:0] OFF_SWITCHER_MASKS    = 8'h22;
    localparam logic [7:0] OFF_LINEAR_MASKS      = 8'h23;
    localparam logic [7:0] OFF_LOAD_SELECT       = 8'h24;
    localparam logic [7:0] OFF_LOAD_HIGH         = 8'h25;
    localparam logic [7:0] OFF_LOAD_LOW          = 8'h26;

    // buck a control field positions, plus the part id position in the revision register
    localparam int unsigned POS_FORCE_MULTIPHASE = 4;
    localparam int unsigned POS_FORCE_PWM        = 3;
    localparam int unsigned POS_DISCHARGE_ENABLE = 2;
    localparam int unsigned POS_PIN_GATING       = 1;
    localparam int unsigned POS_ENABLE           = 0;
    localparam int unsigned POS_PART_ID          = 6;

    // reset values
    localparam logic [4:0] RST_BUCK_A_CONTROL = 5'h04;
    localparam logic [5:0] RST_REVISION_RSVD  = 6'h02;
    localparam logic [7:0] RST_CONFIG         = 8'h00;

    // buck a control bits 4:0; bits 7:5 are reserved and read zero
    typedef struct packed {
        logic force_multiphase;
        logic force_pwm;
        logic discharge_enable;
        logic pin_gating;
        logic enable;
    } pmb_sw_ctl_t;

    // steering handed to the buck a power stage
    typedef struct packed {
        logic multiphase;
        logic force_pwm;
        logic discharge_on;
        logic run;
    } pmb_sw_out_t;

    // live state sampled from the analog side
    typedef struct packed {
        logic [3:0] power_good_fault_flags;
        logic [7:0] top_state;
        logic [7:0] sw_state;
        logic [7:0] ld_state;
        logic [7:0] load_high;
        logic [7:0] load_low;
    } pmb_live_t;

    // one byte per event register; also used for the mask registers
    typedef struct packed {
        logic [7:0] top_one;
        logic [7:0] top_two;
        logic [7:0] sw;
        logic [7:0] ld;
    } pmb_events_t;

    // serial port states
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_ACK, ST_RDATA, ST_MACK
    } pmb_state_t;

endpackage : pmb_pkg

/* verilog/pmb_line_watch.sv */
// pmb_line_watch: registers the serial clock and data lines and flags
// clock edges and start and stop conditions, one cycle each.
// assumes: lines already synchronous to the core clock.
`timescale 1ns/10ps
module pmb_line_watch import pmb_pkg::*; (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_sda,
    output logic      o_scl_rise,
    output logic      o_scl_fall,
    output logic      o_start,
    output logic      o_stop
);
    logic [1:0] scl_q, scl_d;
    logic [1:0] sda_q, sda_d;

    // two-deep history of each line
    always_comb begin
        scl_d = {scl_q[0], i_scl};
        sda_d = {sda_q[0], i_sda};
    end

    // lines idle high, so reset to high to avoid a false stop
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            scl_q <= 2'h3;
            sda_q <= 2'h3;
        end else begin
            scl_q <= scl_d;
            sda_q <= sda_d;
        end
    end

    // edge and condition decode from the history
    assign o_sda      = sda_q[0];
    assign o_scl_rise = scl_q[0] & ~scl_q[1];
    assign o_scl_fall = ~scl_q[0] & scl_q[1];
    assign o_start    = scl_q[0] & scl_q[1] & ~sda_q[0] & sda_q[1];
    assign o_stop     = scl_q[0] & scl_q[1] & sda_q[0] & ~sda_q[1];

endmodule : pmb_line_watch

/* verilog/pmb_switcher_a.sv */
// pmb_switcher_a: turns the buck a control bits and the enable pin into
// registered steering for the power stage.
// assumes: enable pin synchronous to the core clock.
`timescale 1ns/10ps
module pmb_switcher_a import pmb_pkg::*; (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire pmb_sw_ctl_t i_ctl,
    input  wire logic        i_en_pin,
    output pmb_sw_out_t      o_stage
);
    pmb_sw_out_t stage_q, stage_d;

    always_comb begin
        stage_d.run          = i_ctl.enable & (~i_ctl.pin_gating | i_en_pin);
        stage_d.multiphase   = i_ctl.force_multiphase;
        stage_d.force_pwm    = i_ctl.force_pwm | i_ctl.force_multiphase;
        stage_d.discharge_on = i_ctl.discharge_enable & ~stage_d.run;
    end

    // off, no discharge until the control register settles
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            stage_q <= '0;
        end else begin
            stage_q <= stage_d;
        end
    end

    assign o_stage = stage_q;

    enable_stop_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_ctl.enable |=> !o_stage.run)
        else $error("buck a runs with enable bit clear");

    pin_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ctl.enable && i_ctl.pin_gating && !i_en_pin |=> !o_stage.run)
        else $error("buck a runs with gating pin low");

    discharge_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ctl.discharge_enable && !i_ctl.enable |=> o_stage.discharge_on && !o_stage.run)
        else $error("discharge not applied while buck a is off");

    force_phase_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ctl.force_multiphase |=> o_stage.multiphase && o_stage.force_pwm)
        else $error("forced multiphase without forced pwm");

    auto_mode_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_ctl.force_pwm && !i_ctl.force_multiphase |=> !o_stage.force_pwm)
        else $error("pwm forced while auto mode selected");

endmodule : pmb_switcher_a

/* verilog/pmb_register_bank.sv */
// pmb_register_bank: serial-port register bank of the dual buck, dual
// linear regulator; holds buck a control, power-good, event, mask and
// load-measurement registers and drives the buck a steering.
// assumes: serial lines, enable pin, live state and event pulses are all
// synchronous to I_CORE_CLK; the clock is far faster than the serial clock.
//
// What this block does
// - bit 4 forces multiphase forced-pwm; clear lets phases add and shed.
// - bit 3 forces continuous pwm; clear allows automatic pfm/pwm moves unless bit 4 is set.
// - bit 2, default one, connects discharge resistor while buck a is off.
// - bit 1 set makes enable bit and enable pin both required.
// - bit 0 turns buck a on, subject to the enable source choice.
// - revision register: two-bit part id over six reserved bits, read-only.
// - factory revision register returns an eight-bit read-only code.
// - host reaches registers by serial port, index byte after address.
// - write index increments per data byte; reads never increment.
`timescale 1ns/10ps
module pmb_register_bank import pmb_pkg::*; #(
    parameter logic [1:0] PART_ID    = 2'h1, // arbitrary value
    parameter logic [7:0] FACTORY_ID = 8'h5A // arbitrary value
) (
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_SCL,
    input  wire logic        I_SDA,
    input  wire logic        I_EN_PIN,
    input  wire pmb_live_t   I_LIVE,
    input  wire pmb_events_t I_EVENTS,
    output logic             O_SDA,
    output logic             O_SDA_OE,
    output pmb_sw_out_t      O_SWITCHER_A,
    output logic [7:0]       O_PGOOD_CONFIG_ONE,
    output logic [7:0]       O_PGOOD_CONFIG_TWO,
    output logic [7:0]       O_SOFTWARE_RESET,
    output logic [7:0]       O_LOAD_SELECT,
    output pmb_events_t      O_EVENT_MASKS,
    output pmb_events_t      O_EVENT_FLAGS
);

    // sticky flag update: hardware set wins over a write-one clear
    function automatic logic [7:0] flag_next(
        input logic [7:0] cur,
        input logic [7:0] set,
        input logic       hit,
        input logic [7:0] data
    );
        logic [7:0] clr;
        clr = hit ? data : 8'h00;
        flag_next = (cur & ~clr) | set;
    endfunction : flag_next

    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;

    // line edges and bus conditions
    pmb_line_watch u_watch (
        .i_clk      (I_CORE_CLK),
        .i_rst      (I_RST),
        .i_scl      (I_SCL),
        .i_sda      (I_SDA),
        .o_sda      (sda),
        .o_scl_rise (scl_rise),
        .o_scl_fall (scl_fall),
        .o_start    (start),
        .o_stop     (stop)
    );

    // serial port state
    pmb_state_t state_q, state_d;
    pmb_state_t after_q, after_d;
    logic [2:0] cnt_q, cnt_d;
    logic [7:0] shreg_q, shreg_d;
    logic [7:0] idx_q, idx_d;
    logic       got_q, got_d;
    logic       oe_q, oe_d;
    logic       wr_en;
    logic [7:0] rd_byte;

    // register state
    pmb_sw_ctl_t sw_ctl_q, sw_ctl_d;
    logic [7:0]  pg_one_q, pg_one_d;
    logic [7:0]  pg_two_q, pg_two_d;
    logic [7:0]  sw_rst_q, sw_rst_d;
    logic [7:0]  lsel_q, lsel_d;
    pmb_events_t masks_q, masks_d;
    pmb_events_t flags_q, flags_d;

    // serial port next state: bytes shift in on clock rise, the
    // acknowledge and read bits change only on clock fall
    always_comb begin
        state_d = state_q;
        after_d = after_q;
        cnt_d   = cnt_q;
        shreg_d = shreg_q;
        idx_d   = idx_q;
        got_d   = got_q;
        oe_d    = oe_q;
        wr_en   = 1'b0;
        if (stop) begin
            state_d = ST_IDLE;
            oe_d    = 1'b0;
            got_d   = 1'b0;
        end else if (start) begin
            // repeated start also lands here, index kept
            state_d = ST_ADDR;
            cnt_d   = 3'h0;
            got_d   = 1'b0;
            oe_d    = 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    state_d = ST_IDLE;
                end
                ST_ADDR, ST_REG, ST_WDATA: begin
                    if (scl_rise) begin
                        shreg_d = {shreg_q[6:0], sda};
                        cnt_d   = cnt_q + 3'h1;
                        got_d   = (cnt_q == 3'h7);
                    end else if (scl_fall && got_q) begin
                        got_d   = 1'b0;
                        oe_d    = 1'b1;
                        state_d = ST_ACK;
                        if (state_q == ST_ADDR) begin
                            if (shreg_q[7:1] != DEV_ADDR) begin
                                oe_d    = 1'b0;
                                state_d = ST_IDLE;
                            end
                            after_d = shreg_q[0] ? ST_RDATA : ST_REG;
                        end else if (state_q == ST_REG) begin
                            idx_d   = shreg_q;
                            after_d = ST_WDATA;
                        end else begin
                            wr_en   = 1'b1;
                            idx_d   = idx_q + 8'h01;
                            after_d = ST_WDATA;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        cnt_d   = 3'h0;
                        state_d = after_q;
                        oe_d    = 1'b0;
                        if (after_q == ST_RDATA) begin
                            shreg_d = rd_byte;
                            oe_d    = ~rd_byte[7];
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        shreg_d = {shreg_q[6:0], 1'b0};
                        cnt_d   = cnt_q + 3'h1;
                        got_d   = (cnt_q == 3'h7);
                    end else if (scl_fall) begin
                        if (got_q) begin
                            got_d   = 1'b0;
                            oe_d    = 1'b0;
                            state_d = ST_MACK;
                        end else begin
                            oe_d = ~shreg_q[7];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        got_d = ~sda;
                    end else if (scl_fall) begin
                        if (got_q) begin
                            got_d   = 1'b0;
                            cnt_d   = 3'h0;
                            shreg_d = rd_byte;
                            oe_d    = ~rd_byte[7];
                            state_d = ST_RDATA;
                        end else begin
                            state_d = ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // port released after reset; the line then floats high
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            state_q <= ST_IDLE;
            after_q <= ST_IDLE;
            cnt_q   <= 3'h0;
            shreg_q <= 8'h00;
            idx_q   <= 8'h00;
            got_q   <= 1'b0;
            oe_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            after_q <= after_d;
            cnt_q   <= cnt_d;
            shreg_q <= shreg_d;
            idx_q   <= idx_d;
            got_q   <= got_d;
            oe_q    <= oe_d;
        end
    end

    // read mux; unmapped and out-of-bank indices read zero
    always_comb begin
        case (idx_q)
            // fixed id over fixed reserved field
            OFF_DEVICE_REVISION:  rd_byte = {PART_ID, RST_REVISION_RSVD};
            OFF_FACTORY_REVISION: rd_byte = FACTORY_ID;
            OFF_BUCK_A_CONTROL:   rd_byte = {3'h0, sw_ctl_q};
            OFF_PGOOD_CONFIG_ONE: rd_byte = pg_one_q;
            OFF_PGOOD_CONFIG_TWO: rd_byte = pg_two_q;
            OFF_PGOOD_FAULT:      rd_byte = {4'h0, I_LIVE.power_good_fault_flags};
            OFF_SOFTWARE_RESET:   rd_byte = sw_rst_q;
            OFF_TOP_FLAGS_ONE:    rd_byte = flags_q.top_one;
            OFF_TOP_FLAGS_TWO:    rd_byte = flags_q.top_two;
            OFF_SWITCHER_FLAGS:   rd_byte = flags_q.sw;
            OFF_LINEAR_FLAGS:     rd_byte = flags_q.ld;
            OFF_TOP_LIVE:         rd_byte = I_LIVE.top_state;
            OFF_SWITCHER_LIVE:    rd_byte = I_LIVE.sw_state;
            OFF_LINEAR_LIVE:      rd_byte = I_LIVE.ld_state;
            OFF_TOP_MASKS_ONE:    rd_byte = masks_q.top_one;
            OFF_TOP_MASKS_TWO:    rd_byte = masks_q.top_two;
            OFF_SWITCHER_MASKS:   rd_byte = masks_q.sw;
            OFF_LINEAR_MASKS:     rd_byte = masks_q.ld;
            OFF_LOAD_SELECT:      rd_byte = lsel_q;
            OFF_LOAD_HIGH:        rd_byte = I_LIVE.load_high;
            OFF_LOAD_LOW:         rd_byte = I_LIVE.load_low;
            default:              rd_byte = 8'h00;
        endcase
    end

    // register writes; writes to read-only indices are dropped
    always_comb begin
        sw_ctl_d = sw_ctl_q;
        pg_one_d = pg_one_q;
        pg_two_d = pg_two_q;
        sw_rst_d = sw_rst_q;
        lsel_d   = lsel_q;
        masks_d  = masks_q;
        flags_d.top_one = flag_next(flags_q.top_one, I_EVENTS.top_one,
                                    wr_en && idx_q == OFF_TOP_FLAGS_ONE, shreg_q);
        flags_d.top_two = flag_next(flags_q.top_two, I_EVENTS.top_two,
                                    wr_en && idx_q == OFF_TOP_FLAGS_TWO, shreg_q);
        flags_d.sw      = flag_next(flags_q.sw, I_EVENTS.sw,
                                    wr_en && idx_q == OFF_SWITCHER_FLAGS, shreg_q);
        flags_d.ld      = flag_next(flags_q.ld, I_EVENTS.ld,
                                    wr_en && idx_q == OFF_LINEAR_FLAGS, shreg_q);
        if (wr_en) begin
            case (idx_q)
                OFF_BUCK_A_CONTROL:   sw_ctl_d = pmb_sw_ctl_t'(shreg_q[4:0]);
                OFF_PGOOD_CONFIG_ONE: pg_one_d = shreg_q;
                OFF_PGOOD_CONFIG_TWO: pg_two_d = shreg_q;
                OFF_SOFTWARE_RESET:   sw_rst_d = shreg_q;
                OFF_TOP_MASKS_ONE:    masks_d.top_one = shreg_q;
                OFF_TOP_MASKS_TWO:    masks_d.top_two = shreg_q;
                OFF_SWITCHER_MASKS:   masks_d.sw = shreg_q;
                OFF_LINEAR_MASKS:     masks_d.ld = shreg_q;
                OFF_LOAD_SELECT:      lsel_d = shreg_q;
                default:              lsel_d = lsel_q;
            endcase
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            sw_ctl_q <= pmb_sw_ctl_t'(RST_BUCK_A_CONTROL);
            pg_one_q <= RST_CONFIG;
            pg_two_q <= RST_CONFIG;
            sw_rst_q <= RST_CONFIG;
            lsel_q   <= RST_CONFIG;
            masks_q  <= '0;
            flags_q  <= '0;
        end else begin
            sw_ctl_q <= sw_ctl_d;
            pg_one_q <= pg_one_d;
            pg_two_q <= pg_two_d;
            sw_rst_q <= sw_rst_d;
            lsel_q   <= lsel_d;
            masks_q  <= masks_d;
            flags_q  <= flags_d;
        end
    end

    // buck a steering, registered inside
    pmb_switcher_a u_switcher_a (
        .i_clk    (I_CORE_CLK),
        .i_rst    (I_RST),
        .i_ctl    (sw_ctl_q),
        .i_en_pin (I_EN_PIN),
        .o_stage  (O_SWITCHER_A)
    );

    // open-drain: the data pin only ever pulls low
    assign O_SDA              = 1'b0;
    assign O_SDA_OE           = oe_q;
    assign O_PGOOD_CONFIG_ONE = pg_one_q;
    assign O_PGOOD_CONFIG_TWO = pg_two_q;
    assign O_SOFTWARE_RESET   = sw_rst_q;
    assign O_LOAD_SELECT      = lsel_q;
    assign O_EVENT_MASKS      = masks_q;
    assign O_EVENT_FLAGS      = flags_q;

    revision_fixed_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        state_q == ST_ACK && after_q == ST_RDATA && scl_fall
        && idx_q == OFF_DEVICE_REVISION |=> shreg_q == {PART_ID, RST_REVISION_RSVD})
        else $error("revision register changed");

    factory_code_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        state_q == ST_ACK && after_q == ST_RDATA && scl_fall
        && idx_q == OFF_FACTORY_REVISION |=> shreg_q == FACTORY_ID)
        else $error("factory code register changed");

    write_step_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        wr_en |=> idx_q == $past(idx_q) + 8'h01)
        else $error("index did not step after a data byte");

    read_hold_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        (state_q == ST_RDATA || state_q == ST_MACK) && !start |=> $stable(idx_q))
        else $error("index moved during a read");

    reserved_zero_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        state_q == ST_RDATA && cnt_q == 3'h0 && idx_q == OFF_BUCK_A_CONTROL
        |-> shreg_q[7:5] == 3'h0)
        else $error("reserved buck control bits read nonzero");

    ack_drive_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        state_q == ST_ACK && !stop && !start |-> O_SDA_OE)
        else $error("acknowledge not driven");

    foreign_addr_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        state_q == ST_ADDR && scl_fall && got_q && shreg_q[7:1] != DEV_ADDR
        |=> state_q == ST_IDLE && !O_SDA_OE)
        else $error("answered a foreign address");

    // written enable reaches stage in two cycles
    enable_path_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        wr_en && idx_q == OFF_BUCK_A_CONTROL && shreg_q[POS_ENABLE]
        && !shreg_q[POS_PIN_GATING] |=> ##1 O_SWITCHER_A.run)
        else $error("enable write did not start buck a");

endmodule : pmb_register_bank

/* tb/pmb_host.sv */
// pmb_host: serial port master model for the register bank.
// assumes: device pulls data low while its enable is high; pull-up.
`timescale 1ns/10ps
module pmb_host (
    input  wire logic clk,
    input  wire logic sda_oe,
    output logic      scl,
    output logic      sda
);
    logic drv = 1'b1;
    initial scl = 1'b1;
    // open-drain line, released level is high
    assign sda = drv & ~sda_oe;
    // each phase holds five core clocks
    task automatic step(input logic c, input logic d);
        @(posedge clk);
        scl <= c;
        drv <= d;
        repeat (4) @(posedge clk);
    endtask : step
    // data only moves while the clock is low
    task automatic bit_io(input logic b, output logic r);
        step(1'b0, drv);
        step(1'b0, b);
        step(1'b1, b);
        r = sda;
    endtask : bit_io
    task automatic start();
        step(1'b0, drv);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask : start
    task automatic stop();
        step(1'b0, drv);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask : stop
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r,
                        output logic k);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(a, k);
    endtask : xfer
endmodule : pmb_host

/* tb/test_pmic_control_register_bank.sv */
// test_pmic_control_register_bank: register reads, writes and buck a steering.
// assumes: host model drives the serial lines; one 100 MHz clock.
`timescale 1ns/10ps
module test_pmic_control_register_bank import pmb_pkg::*;;
    localparam logic [1:0] PID = 2'h2;  // arbitrary value
    localparam logic [7:0] FID = 8'hC3; // arbitrary value
    logic        clk, rst, pin, scl, sda, oe, sdo;
    pmb_sw_out_t sw;
    logic [7:0]  cfg1, cfg2, srst, lsel, r;
    pmb_events_t ev, msk, flg;
    pmb_live_t   live;
    logic        k;
    int          miscompares = 0, checks_done = 0;
    logic [15:0] tbl [8] = '{16'h0101, 16'hE300, 16'h0311, 16'h100C,
                             16'h0804, 16'h0402, 16'h0702, 16'h0000};
    pmb_host host (.clk(clk), .sda_oe(oe), .scl(scl), .sda(sda));
    pmb_register_bank #(.PART_ID(PID), .FACTORY_ID(FID)) uut (
        .I_CORE_CLK(clk), .I_RST(rst), .I_SCL(scl), .I_SDA(sda), .I_EN_PIN(pin),
        .I_LIVE(live), .I_EVENTS(ev), .O_SDA(sdo), .O_SDA_OE(oe), .O_SWITCHER_A(sw),
        .O_PGOOD_CONFIG_ONE(cfg1), .O_PGOOD_CONFIG_TWO(cfg2), .O_SOFTWARE_RESET(srst),
        .O_LOAD_SELECT(lsel), .O_EVENT_MASKS(msk), .O_EVENT_FLAGS(flg));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    // address, index, then data bytes
    task automatic wr(input logic [7:0] idx, input logic [15:0] d, input int n);
        host.start();
        host.xfer({DEV_ADDR, 1'b0}, 1'b1, r, k);
        chk({7'h0, k}, 8'h00);
        host.xfer(idx, 1'b1, r, k);
        for (int i = 0; i < n; i++) begin
            host.xfer(d[15:8], 1'b1, r, k);
            d = d << 8;
        end
        host.stop();
    endtask : wr
    // two bytes read back, master ack between them
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        host.start();
        host.xfer({DEV_ADDR, 1'b0}, 1'b1, r, k);
        host.xfer(idx, 1'b1, r, k);
        host.start();
        host.xfer({DEV_ADDR, 1'b1}, 1'b1, r, k);
        host.xfer(8'hFF, 1'b0, r, k);
        chk(r, exp);
        host.xfer(8'hFF, 1'b1, r, k);
        chk(r, exp);
        host.stop();
    endtask : rd
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        rst = 1'b1;
        pin = 1'b0;
        ev = '0;
        live = {4'h9, 8'h81, 8'h42, 8'h24, 8'h3C, 8'hC3};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk({4'h0, sw}, 8'h02);
        chk({7'h0, sdo}, 8'h00);
        rd(OFF_BUCK_A_CONTROL, 8'h04);
        wr(OFF_DEVICE_REVISION, 16'hFFFF, 2);
        rd(OFF_DEVICE_REVISION, {PID, 6'h02});
        rd(OFF_FACTORY_REVISION, FID);
        wr(OFF_PGOOD_CONFIG_ONE, 16'hA53C, 2);
        chk(cfg1, 8'hA5);
        chk(cfg2, 8'h3C);
        rd(OFF_PGOOD_CONFIG_TWO, 8'h3C);
        rd(8'h30, 8'h00);
        host.start();
        host.xfer({7'h61, 1'b0}, 1'b1, r, k);
        chk({7'h0, k}, 8'h01);
        host.stop();
        rd(OFF_PGOOD_FAULT, 8'h09);
        rd(OFF_LOAD_LOW, 8'hC3);
        wr(OFF_SOFTWARE_RESET, 16'h8101, 2);
        chk(srst, 8'h81);
        wr(OFF_SWITCHER_MASKS, 16'h5AC3, 2);
        chk(msk.sw, 8'h5A);
        chk(msk.ld, 8'hC3);
        wr(OFF_LOAD_SELECT, 16'h0100, 1);
        chk(lsel, 8'h01);
        // one-cycle event pulse sets sticky flags; written ones clear them
        ev.sw <= 8'h21;
        @(posedge clk);
        ev.sw <= 8'h00;
        @(posedge clk);
        chk(flg.sw, 8'h21);
        rd(OFF_SWITCHER_FLAGS, 8'h21);
        wr(OFF_SWITCHER_FLAGS, 16'h0100, 1);
        chk(flg.sw, 8'h20);
        // mid-run reset while the lines idle high
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk(cfg1, 8'h00);
        chk(flg.sw, 8'h00);
        chk({4'h0, sw}, 8'h02);
        rd(OFF_BUCK_A_CONTROL, 8'h04);
        // steering table: data, pin, expected stage
        for (int i = 0; i < 8; i++) begin
            pin <= tbl[i][4];
            wr(OFF_BUCK_A_CONTROL, tbl[i], 1);
            chk({4'h0, sw}, {4'h0, tbl[i][3:0]});
            rd(OFF_BUCK_A_CONTROL, tbl[i][15:8] & 8'h1F);
        end
        tally_and_finish();
    end
endmodule : test_pmic_control_register_bank
